// file: dv/tw8_port_model.sv
// Purpose: port pin direction and output logic beside one channel
// Assumes: software values arrive as levels
// Notes: released pad rests at its pull-up
module tw8_port_model (
	// clock
	input wire sys_clk,
	// software view
	input wire dir_in,
	input wire data_in,
	// design side
	input wire pin_out,
	input wire pin_oe,
	output reg dir_bit,
	output reg port_data,
	// pad
	output wire pad
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk) begin
		dir_bit <= dir_in;
		port_data <= data_in;
	end
	assign pad = pin_oe ? pin_out : 1'b1;
endmodule

// file: dv/tw8_timer_props.sv
// Purpose: port-level checks for the timer waveform block
// Assumes: one clock domain, resetn async active low
// Notes: bound to the design top below
module tw8_props (
	// clock and reset
	input wire sys_clk,
	input wire resetn,
	// pin logic
	input wire compare_pin_direction_bit_a,
	input wire compare_pin_direction_bit_b,
	input wire pin_oe_a,
	input wire pin_oe_b,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_dir_a_kept: assert property (
		pin_oe_a == compare_pin_direction_bit_a) else $error("oe a wrong");
	a_dir_b_kept: assert property (
		pin_oe_b == compare_pin_direction_bit_b) else $error("oe b wrong");
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("aw taken during response");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar taken during response");
	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("no write response");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("no read response");
endmodule

bind tw8_timer tw8_props i_tw8_props (.sys_clk, .resetn,
	.compare_pin_direction_bit_a, .compare_pin_direction_bit_b,
	.pin_oe_a, .pin_oe_b, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);

// file: dv/tw8_timer_tb.sv
// Purpose: self-checking bench for the timer waveform block
// Assumes: ticks are issued in bursts so counts are exact
// Notes: bready and rready are sometimes raised late to hold answers
`include "tw8_map.vh"
module tw8_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic tick_en = 1'b0;
	logic dir_a = 1'b0;
	logic dat_a = 1'b0;
	logic dir_b = 1'b0;
	logic dat_b = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic [1:0] rsp;
	logic [31:0] v;
	logic [7:0] c;
	logic st;
	int seed;
	int n_fail = 0;
	int cmp_count = 0;
	wire awready, wready, bvalid, arready, rvalid, pa, pb, oa, ob;
	wire dbit_a, pdat_a, pad_a;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	tw8_timer i_tw8_timer (.sys_clk, .resetn, .tick_en,
		.port_data_a(pdat_a), .port_data_b(dat_b),
		.compare_pin_direction_bit_a(dbit_a),
		.compare_pin_direction_bit_b(dir_b), .pin_out_a(pa),
		.pin_out_b(pb), .pin_oe_a(oa), .pin_oe_b(ob),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	tw8_port_model i_tw8_port_model (.sys_clk, .dir_in(dir_a),
		.data_in(dat_a), .pin_out(pa), .pin_oe(oa), .dir_bit(dbit_a),
		.port_data(pdat_a), .pad(pad_a));
	always #2.5 sys_clk = ~sys_clk;
	function automatic logic [31:0] ctrl(input int m, input int aa,
		input int ab);
		return 32'(m + aa * 16 + ab * 64);
	endfunction
	function automatic logic nxt(input int act, input logic cur);
		case (act)
			0: return cur;
			1: return ~cur;
			2: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb, lb;
		n = 0;
		tb = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// a late bready makes the slave hold its response
		bready <= 1'($random(seed));
		while (!tb && n < 50) begin
			@(negedge sys_clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			lb = bvalid && !bready;
			rsp = bresp;
			@(posedge sys_clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (lb)
				bready <= 1'b1;
			n++;
		end
		if (!tb)
			n_fail++;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		int n;
		logic ta, tr, lr;
		n = 0;
		tr = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		// a late rready makes the slave hold its read data
		rready <= 1'($random(seed));
		while (!tr && n < 50) begin
			@(negedge sys_clk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			lr = rvalid && !rready;
			v = rdata;
			rsp = rresp;
			@(posedge sys_clk);
			if (ta)
				arvalid <= 1'b0;
			if (lr)
				rready <= 1'b1;
			n++;
		end
		if (!tr)
			n_fail++;
		chk(v & m, e);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			tick_en <= 1'b1;
			@(posedge sys_clk);
		end
		tick_en <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rst;
		resetn <= 1'b0;
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#250000;
		n_fail++;
		end_sim;
	end
	initial begin
		seed = 47;
		rst;
		rd(`TW8_STAT_OFS, 32'h7, 32'h0);
		rd(8'h18, 32'hffff_ffff, 32'h0);
		chk(rsp, `TW8_RESP_SLVERR);
		wr(8'h18, 32'h0);
		chk(rsp, `TW8_RESP_SLVERR);
		tick(255);
		rd(`TW8_CNT_OFS, 32'hff, 32'hff);
		rd(`TW8_FLAG_OFS, 32'h1, 32'h0);
		tick(1);
		rd(`TW8_FLAG_OFS, 32'h1, 32'h1);
		repeat (20) @(posedge sys_clk);
		rd(`TW8_CNT_OFS, 32'hff, 32'h0);
		// force with the pin released: set, clear, toggle, none
		wr(`TW8_FLAG_OFS, 32'h7);
		st = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			wr(`TW8_CTRL_OFS, ctrl(0, i, 0) | 32'h100);
			st = nxt(i, st);
			rd(`TW8_STAT_OFS, 32'h1, {31'h0, st});
		end
		chk(pad_a, 1'b1);
		rd(`TW8_FLAG_OFS, 32'h2, 32'h0);
		rd(`TW8_CNT_OFS, 32'hff, 32'h0);
		dir_a <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(pa, 1'b0);
		wr(`TW8_CTRL_OFS, ctrl(0, 1, 0));
		repeat (3) @(posedge sys_clk);
		chk(pad_a, 1'b1);
		chk(pb, 1'b1);
		for (int k = 0; k < 3; k++) begin
			c = 8'(1 + ($random(seed) & 31));
			rst;
			wr(`TW8_CMPA_OFS, {24'h0, c});
			wr(`TW8_CTRL_OFS, ctrl(2, 1, 0));
			tick(c + 1);
			rd(`TW8_CNT_OFS, 32'hff, 32'h0);
			rd(`TW8_FLAG_OFS, 32'h2, 32'h2);
			rd(`TW8_STAT_OFS, 32'h1, 32'h1);
			tick(c);
			wr(`TW8_FLAG_OFS, 32'h7);
			wr(`TW8_CMPA_OFS, {24'h0, c - 8'h01});
			tick(256 - c);
			rd(`TW8_FLAG_OFS, 32'h3, 32'h1);
		end
		rst;
		wr(`TW8_CMPB_OFS, 32'h80);
		wr(`TW8_CTRL_OFS, ctrl(3, 0, 2));
		tick(383);
		rd(`TW8_STAT_OFS, 32'h2, 32'h2);
		tick(2);
		rd(`TW8_STAT_OFS, 32'h2, 32'h0);
		wr(`TW8_FLAG_OFS, 32'h7);
		tick(126);
		rd(`TW8_CNT_OFS, 32'hff, 32'hff);
		tick(1);
		rd(`TW8_CNT_OFS, 32'hff, 32'h0);
		rd(`TW8_FLAG_OFS, 32'h1, 32'h1);
		// pwm compare write waits in the buffer until top
		wr(`TW8_CMPB_OFS, 32'h10);
		rd(`TW8_CMPB_OFS, 32'hff, 32'h10);
		tick(17);
		rd(`TW8_STAT_OFS, 32'h2, 32'h2);
		rst;
		wr(`TW8_CMPA_OFS, 32'h5);
		wr(`TW8_CTRL_OFS, ctrl(7, 1, 0));
		tick(6);
		rd(`TW8_CNT_OFS, 32'hff, 32'h0);
		rd(`TW8_STAT_OFS, 32'h1, 32'h1);
		tick(6);
		rd(`TW8_STAT_OFS, 32'h1, 32'h0);
		rst;
		wr(`TW8_CTRL_OFS, ctrl(3, 0, 2));
		tick(256);
		rd(`TW8_STAT_OFS, 32'h2, 32'h2);
		tick(1);
		rd(`TW8_STAT_OFS, 32'h2, 32'h0);
		rst;
		wr(`TW8_CMPB_OFS, 32'h40);
		wr(`TW8_CTRL_OFS, ctrl(1, 1, 2));
		tick(256);
		rd(`TW8_CNT_OFS, 32'hff, 32'hfe);
		rd(`TW8_STAT_OFS, 32'h5, 32'h4);
		wr(`TW8_FLAG_OFS, 32'h7);
		tick(254);
		rd(`TW8_FLAG_OFS, 32'h1, 32'h1);
		rd(`TW8_STAT_OFS, 32'h3, 32'h2);
		tick(65);
		rd(`TW8_STAT_OFS, 32'h2, 32'h0);
		end_sim;
	end
endmodule

// file: hdl/tw8_map.vh
`ifndef TW8_MAP_VH
`define TW8_MAP_VH
// register byte offsets (AXI4-Lite, one word each)
`define TW8_CTRL_OFS 8'h00
`define TW8_CNT_OFS 8'h04
`define TW8_CMPA_OFS 8'h08
`define TW8_CMPB_OFS 8'h0c
`define TW8_FLAG_OFS 8'h10
`define TW8_STAT_OFS 8'h14
// control fields
`define TW8_CTRL_MODE_LSB 0
`define TW8_CTRL_ACTA_LSB 4
`define TW8_CTRL_ACTB_LSB 6
`define TW8_CTRL_FORCEA_BIT 8
`define TW8_CTRL_FORCEB_BIT 9
// flag bits
`define TW8_FLAG_OVF_BIT 0
`define TW8_FLAG_CMPA_BIT 1
`define TW8_FLAG_CMPB_BIT 2
// status bits
`define TW8_STAT_OUTA_BIT 0
`define TW8_STAT_OUTB_BIT 1
`define TW8_STAT_DOWN_BIT 2
// waveform modes
`define TW8_MODE_NORMAL 3'h0
`define TW8_MODE_PC_MAX 3'h1
`define TW8_MODE_CLEAR_ON_MATCH 3'h2
`define TW8_MODE_FAST_MAX 3'h3
`define TW8_MODE_PC_CMPA 3'h5
`define TW8_MODE_FAST_CMPA 3'h7
// counter extremes
`define TW8_MAX 8'hff
`define TW8_BOTTOM 8'h00
// axi responses
`define TW8_RESP_OKAY 2'h0
`define TW8_RESP_SLVERR 2'h2
`endif

// file: hdl/tw8_timer.v
// Purpose: 8-bit timer waveform generator with two compare outputs
// Assumes: tick_en is a one-cycle timer clock enable from a prescaler
// Notes: registers over AXI4-Lite; compare outputs feed port pin logic
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`include "tw8_map.vh"

module tw8_timer (
	// clock and reset
	input wire sys_clk,
	input wire resetn,
	// timer clock enable
	input wire tick_en,
	// port pin logic
	input wire port_data_a,
	input wire port_data_b,
	input wire compare_pin_direction_bit_a,
	input wire compare_pin_direction_bit_b,
	output reg pin_out_a,
	output reg pin_out_b,
	output wire pin_oe_a,
	output wire pin_oe_b,
	// axi4-lite write address
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	reg [2:0] waveform_mode_select;
	reg [1:0] output_action_field_a;
	reg [1:0] output_action_field_b;
	reg [7:0] count_value;
	reg [7:0] compare_value_a;
	reg [7:0] compare_value_b;
	reg [7:0] cmp_buf_a;
	reg [7:0] cmp_buf_b;
	reg count_down;
	reg overflow_flag;
	reg compare_flag_a;
	reg compare_flag_b;
	reg compare_output_state_a;
	reg compare_output_state_b;
	reg block_match;
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	wire is_fast;
	wire is_pc;
	wire pwm;
	wire [7:0] top;
	wire at_top;
	wire match_a;
	wire match_b;
	wire wr_go;
	wire wr_ctrl;
	wire wr_cnt;
	wire wr_cmpa;
	wire wr_cmpb;
	wire wr_flag;
	wire force_a;
	wire force_b;
	wire [7:0] next_count;
	wire next_down;

	// output action: returns new state for a match event
	// kind: 0 plain match, 1 match counting down, 2 top of fast pwm
	function tw8_act;
		input [2:0] mode;
		input [1:0] act;
		input [1:0] kind;
		input cur;
		reg f;
		reg p;
		begin
			f = (mode == `TW8_MODE_FAST_MAX) ||
				(mode == `TW8_MODE_FAST_CMPA);
			p = (mode == `TW8_MODE_PC_MAX) ||
				(mode == `TW8_MODE_PC_CMPA);
			tw8_act = cur;
			if (act == 2'h0) begin
				tw8_act = cur;
			end else if (f) begin
				if (kind == 2'h2) begin
					if (act[1])
						tw8_act = ~act[0];
				end else if (act == 2'h1) begin
					tw8_act = ~cur;
				end else begin
					tw8_act = act[0];
				end
			end else if (p) begin
				if (act[1])
					tw8_act = (kind == 2'h1) ? ~act[0] : act[0];
				// action one reserved here
			end else if (mode == `TW8_MODE_NORMAL ||
				mode == `TW8_MODE_CLEAR_ON_MATCH) begin
				case (act)
				2'h1: tw8_act = ~cur;
				2'h2: tw8_act = 1'b0;
				2'h3: tw8_act = 1'b1;
				default: tw8_act = cur;
				endcase
			end else begin
				tw8_act = cur;
			end
		end
	endfunction

	// mode-only decode; action fields never enter the count path
	assign is_fast = (waveform_mode_select == `TW8_MODE_FAST_MAX) ||
		(waveform_mode_select == `TW8_MODE_FAST_CMPA);
	assign is_pc = (waveform_mode_select == `TW8_MODE_PC_MAX) ||
		(waveform_mode_select == `TW8_MODE_PC_CMPA);
	assign pwm = is_fast || is_pc;
	assign top = waveform_mode_select[2] ? compare_value_a : `TW8_MAX;
	assign at_top = (count_value == top);
	// a counter write masks matches for the next timer clock
	assign match_a = (count_value == compare_value_a) && !block_match;
	assign match_b = (count_value == compare_value_b) && !block_match;

	// counter sequencing
	// phase correct turns at top with no repeat of the top value,
	// so one period takes twice the top value in ticks
	assign next_down = is_pc ? (count_down ? (count_value != 8'h01) :
		at_top) : 1'b0;
	assign next_count =
		(waveform_mode_select == `TW8_MODE_CLEAR_ON_MATCH &&
		(count_value == compare_value_a)) ? `TW8_BOTTOM :
		(is_fast && at_top) ? `TW8_BOTTOM :
		(is_pc && (count_down || at_top)) ? count_value - 8'h01 :
		count_value + 8'h01;

	// axi write channels
	// a write needs address and data both held; a pending response
	// refuses new writes, so at most one answer is outstanding
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wr_ctrl = wr_go && aw_addr == `TW8_CTRL_OFS;
	assign wr_cnt = wr_go && aw_addr == `TW8_CNT_OFS && w_strb[0];
	assign wr_cmpa = wr_go && aw_addr == `TW8_CMPA_OFS && w_strb[0];
	assign wr_cmpb = wr_go && aw_addr == `TW8_CMPB_OFS && w_strb[0];
	assign wr_flag = wr_go && aw_addr == `TW8_FLAG_OFS && w_strb[0];
	// force works only in non-pwm modes
	assign force_a = wr_ctrl && w_strb[1] && !pwm &&
		w_data[`TW8_CTRL_FORCEA_BIT];
	assign force_b = wr_ctrl && w_strb[1] && !pwm &&
		w_data[`TW8_CTRL_FORCEB_BIT];

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TW8_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `TW8_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr <= `TW8_FLAG_OFS) ?
					`TW8_RESP_OKAY : `TW8_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `TW8_RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
				`TW8_CTRL_OFS: s_axi_rdata <= {24'h000000,
					output_action_field_b, output_action_field_a,
					1'b0, waveform_mode_select};
				`TW8_CNT_OFS: s_axi_rdata <= {24'h000000, count_value};
				// in pwm modes software sees the buffer
				`TW8_CMPA_OFS: s_axi_rdata <= {24'h000000, cmp_buf_a};
				`TW8_CMPB_OFS: s_axi_rdata <= {24'h000000, cmp_buf_b};
				`TW8_FLAG_OFS: s_axi_rdata <= {29'h00000000,
					compare_flag_b, compare_flag_a, overflow_flag};
				// status shows the internal states, not the pins
				`TW8_STAT_OFS: s_axi_rdata <= {29'h00000000, count_down,
					compare_output_state_b, compare_output_state_a};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `TW8_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// timer core
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			waveform_mode_select <= `TW8_MODE_NORMAL;
			output_action_field_a <= 2'h0;
			output_action_field_b <= 2'h0;
			count_value <= `TW8_BOTTOM;
			count_down <= 1'b0;
			compare_value_a <= 8'h00;
			compare_value_b <= 8'h00;
			cmp_buf_a <= 8'h00;
			cmp_buf_b <= 8'h00;
			overflow_flag <= 1'b0;
			compare_flag_a <= 1'b0;
			compare_flag_b <= 1'b0;
			compare_output_state_a <= 1'b0;
			compare_output_state_b <= 1'b0;
			block_match <= 1'b0;
		end else begin
			if (wr_ctrl && w_strb[0]) begin
				waveform_mode_select <= w_data[`TW8_CTRL_MODE_LSB +: 3];
				// takes effect at the next match, no retroactive action
				output_action_field_a <= w_data[`TW8_CTRL_ACTA_LSB +: 2];
				output_action_field_b <= w_data[`TW8_CTRL_ACTB_LSB +: 2];
			end
			if (wr_cmpa)
				cmp_buf_a <= w_data[7:0];
			if (wr_cmpb)
				cmp_buf_b <= w_data[7:0];
			// non-pwm: direct write, no double buffer
			if (wr_cmpa && !pwm)
				compare_value_a <= w_data[7:0];
			if (wr_cmpb && !pwm)
				compare_value_b <= w_data[7:0];
			// the block lasts until a tick passes, even with the timer
			// stopped, so a write equal to a compare value raises no flag
			if (wr_cnt)
				block_match <= 1'b1;
			else if (tick_en)
				block_match <= 1'b0;
			// force decodes the mode in effect before this write lands,
			// so mode and force in one write act in the old mode
			// forcing sets the state even with the pin not overridden
			if (force_a)
				compare_output_state_a <= tw8_act(waveform_mode_select,
					w_data[`TW8_CTRL_ACTA_LSB +: 2], 2'h0,
					compare_output_state_a);
			if (force_b)
				compare_output_state_b <= tw8_act(waveform_mode_select,
					w_data[`TW8_CTRL_ACTB_LSB +: 2], 2'h0,
					compare_output_state_b);
			if (tick_en && !wr_cnt) begin
				count_value <= next_count;
				count_down <= next_down;
				// buffered compare update at top (fast) or bottom (pc)
				if (pwm && ((is_fast && at_top) || (is_pc &&
					count_value == `TW8_BOTTOM))) begin
					compare_value_a <= cmp_buf_a;
					compare_value_b <= cmp_buf_b;
				end
				// a match on top outranks the set at top, so a compare
				// of max gives a constant level rather than a glitch
				if (match_a && !force_a)
					compare_output_state_a <= tw8_act(waveform_mode_select,
						output_action_field_a, {1'b0, count_down},
						compare_output_state_a);
				else if (is_fast && at_top && !force_a)
					compare_output_state_a <= tw8_act(waveform_mode_select,
						output_action_field_a, 2'h2,
						compare_output_state_a);
				if (match_b && !force_b)
					compare_output_state_b <= tw8_act(waveform_mode_select,
						output_action_field_b, {1'b0, count_down},
						compare_output_state_b);
				else if (is_fast && at_top && !force_b)
					compare_output_state_b <= tw8_act(waveform_mode_select,
						output_action_field_b, 2'h2,
						compare_output_state_b);
			end else if (wr_cnt) begin
				count_value <= w_data[7:0];
			end
			// flags: hardware set wins over software clear
			// phase correct overflow is taken on the last downward step
			if (tick_en && !wr_cnt && ((!pwm && next_count == `TW8_BOTTOM &&
				count_value == `TW8_MAX) ||
				(is_fast && at_top) ||
				(is_pc && count_down && count_value == 8'h01)))
				overflow_flag <= 1'b1;
			else if (wr_flag && w_data[`TW8_FLAG_OVF_BIT])
				overflow_flag <= 1'b0;
			// a match raises its flag on the tick that leaves the
			// matching count; a counter write on that tick suppresses it
			if (tick_en && !wr_cnt && match_a)
				compare_flag_a <= 1'b1;
			else if (wr_flag && w_data[`TW8_FLAG_CMPA_BIT])
				compare_flag_a <= 1'b0;
			if (tick_en && !wr_cnt && match_b)
				compare_flag_b <= 1'b1;
			else if (wr_flag && w_data[`TW8_FLAG_CMPB_BIT])
				compare_flag_b <= 1'b0;
		end
	end

	// pin override, independent of mode; direction from port
	// the pin value is registered, so an action change shows one clock
	// later on the pin, while the direction path has no delay
	assign pin_oe_a = compare_pin_direction_bit_a;
	assign pin_oe_b = compare_pin_direction_bit_b;
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_out_a <= 1'b0;
			pin_out_b <= 1'b0;
		end else begin
			pin_out_a <= (output_action_field_a != 2'h0) ?
				compare_output_state_a : port_data_a;
			pin_out_b <= (output_action_field_b != 2'h0) ?
				compare_output_state_b : port_data_b;
		end
	end

endmodule
